/* logic/sdf_filter.sv */
// Purpose: Decimating sinc filter with auto settling, behind an AHB-Lite slave
// Assumes: clk_sys is the oscillator clock; modBit is an asynchronous pin
// Notes: Results are raw CIC sums; gain is decimation ratio to the filter order
`timescale 1ns/10ps
`include "sdf_regs.svh"
module sdf_filter #(
  parameter int ACC_W = 36
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic modBit,
  output logic modStrobe,
  output logic sampleStrobe,
  output logic [2:0] channelSel,
  output logic resultValid
);
  import sdf_pkg::*;

  // Bus and register state
  logic wrPend_reg, wrPend_next;
  logic [31:0] wrAddr_reg, wrAddr_next;
  logic [31:0] rdData_reg, rdData_next;
  logic [8:0] ctrl_reg, ctrl_next;
  logic [10:0] decim_reg, decim_next;
  logic ready_reg, ready_next;
  logic [1:0] order_reg, order_next;
  logic [ACC_W-1:0] data_reg, data_next;
  logic cfgRestart;
  logic dataRead;
  logic [10:0] wrDecim;

  // Filter state
  logic bitS1_reg, bitS2_reg;
  logic [ACC_W-1:0] int1_reg, int2_reg, int3_reg;
  logic [ACC_W-1:0] int1_next, int2_next, int3_next;
  logic [ACC_W-1:0] h2a_reg, h2b_reg, h3a_reg, h3b_reg, h3c_reg, h3d_reg;
  logic [ACC_W-1:0] h2a_next, h2b_next, h3a_next, h3b_next, h3c_next, h3d_next;
  logic [10:0] decCnt_reg, decCnt_next;
  sdf_phase_t phase_reg, phase_next;
  logic valid_reg, valid_next;
  logic [ACC_W-1:0] step;
  logic [ACC_W-1:0] comb1, comb2, comb3;
  logic periodEnd;
  logic [1:0] needOrder;
  logic [1:0] periodsDone;
  logic modTick;
  logic sampTick;
  sdf_filt_t mode;

  // Clamp a written ratio into the legal range
  function automatic logic [10:0] clamp_decim(input logic [31:0] w);
    if (w[31:11] != 21'h0) begin
      clamp_decim = `SDF_DECIM_MAX;
    end else if (w[10:0] < `SDF_DECIM_MIN) begin
      clamp_decim = `SDF_DECIM_MIN;
    end else begin
      clamp_decim = w[10:0];
    end
  endfunction

  // Periods completed including the one now ending, saturating at three
  function automatic logic [1:0] phase_count(input sdf_phase_t ph);
    case (ph)
      SDF_PH_NONE: phase_count = 2'h1;
      SDF_PH_ONE: phase_count = 2'h2;
      default: phase_count = 2'h3;
    endcase
  endfunction

  assign mode = sdf_filt_t'(ctrl_reg[`SDF_CTRL_MODE_LSB +: 2]);
  assign channelSel = ctrl_reg[`SDF_CTRL_CHAN_LSB +: 3];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_reg;
  assign modStrobe = modTick;
  assign sampleStrobe = sampTick;
  assign resultValid = valid_reg;

  sdf_rate_gen u_rate (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(cfgRestart),
    .speedSel(ctrl_reg[`SDF_CTRL_SPEED_BIT]),
    .gainCode(ctrl_reg[`SDF_CTRL_GAIN_LSB +: 3]),
    .modTick(modTick),
    .sampTick(sampTick)
  );

  // Register slave: writes land in the data phase, reads are prepared a cycle early
  always_comb begin
    wrPend_next = hsel && hready && htrans[1] && hwrite;
    wrAddr_next = haddr;
    ctrl_next = ctrl_reg;
    decim_next = decim_reg;
    wrDecim = clamp_decim(hwdata);
    cfgRestart = 1'b0;
    if (wrPend_reg && wrAddr_reg == `SDF_CTRL_OFS) begin
      ctrl_next = hwdata[`SDF_CTRL_WIDTH-1:0];
      cfgRestart = (hwdata[`SDF_CTRL_WIDTH-1:0] != ctrl_reg);
    end
    if (wrPend_reg && wrAddr_reg == `SDF_DECIM_OFS) begin
      decim_next = wrDecim;
      cfgRestart = (wrDecim != decim_reg);
    end
    rdData_next = 32'h0000_0000; // Unmapped reads return zero
    dataRead = 1'b0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr)
        `SDF_CTRL_OFS: rdData_next = {23'h000000, ctrl_reg};
        `SDF_DECIM_OFS: rdData_next = {21'h000000, decim_reg};
        `SDF_STATUS_OFS: rdData_next = {28'h0000000, (phase_reg != SDF_PH_MANY),
                                        order_reg, ready_reg};
        `SDF_DATA_LO_OFS: begin
          rdData_next = data_reg[31:0];
          dataRead = 1'b1;
        end
        `SDF_DATA_HI_OFS: rdData_next = 32'(signed'(data_reg[ACC_W-1:32]));
        default: rdData_next = 32'h0000_0000;
      endcase
    end
  end

  // Integrators and combs; a one bit counts plus, a zero minus
  always_comb begin
    step = bitS2_reg ? ACC_W'(1) : '1;
    int1_next = int1_reg;
    int2_next = int2_reg;
    int3_next = int3_reg;
    decCnt_next = decCnt_reg;
    if (modTick) begin
      int1_next = int1_reg + step;
      int2_next = int2_reg + int1_next;
      int3_next = int3_reg + int2_next;
      decCnt_next = (decCnt_reg == decim_reg - 11'h001) ? 11'h000 : decCnt_reg + 11'h001;
    end
    periodEnd = modTick && (decCnt_reg == decim_reg - 11'h001);
    comb1 = int1_next - h2a_reg; // h2a doubles as first-order history
    comb2 = int2_next - (h3a_reg << 1) + h2b_reg;
    comb3 = int3_next - ACC_W'(3) * h3b_reg + ACC_W'(3) * h3c_reg - h3d_reg; // Three periods back
    if (cfgRestart) begin
      int1_next = '0;
      int2_next = '0;
      int3_next = '0;
      decCnt_next = 11'h000;
    end
  end

  // History taps of the combs, taken once per output period
  always_comb begin
    h2a_next = h2a_reg;
    h2b_next = h2b_reg;
    h3a_next = h3a_reg;
    h3b_next = h3b_reg;
    h3c_next = h3c_reg;
    h3d_next = h3d_reg;
    if (periodEnd) begin
      h2a_next = int1_next;
      h3a_next = int2_next;
      h2b_next = h3a_reg;
      h3b_next = int3_next;
      h3c_next = h3b_reg;
      h3d_next = h3c_reg;
    end
    if (cfgRestart) begin
      h2a_next = '0;
      h2b_next = '0;
      h3a_next = '0;
      h3b_next = '0;
      h3c_next = '0;
      h3d_next = '0;
    end
  end

  // Settling sequence and result capture
  always_comb begin
    phase_next = phase_reg;
    periodsDone = phase_count(phase_reg);
    case (mode)
      SDF_FILT_FAST: needOrder = 2'h1;
      SDF_FILT_SINC2: needOrder = 2'h2;
      SDF_FILT_SINC3: needOrder = 2'h3;
      default: needOrder = periodsDone;
    endcase
    valid_next = 1'b0;
    order_next = order_reg;
    data_next = data_reg;
    ready_next = ready_reg && !dataRead;
    if (periodEnd) begin
      case (phase_reg)
        SDF_PH_NONE: phase_next = SDF_PH_ONE;
        SDF_PH_ONE: phase_next = SDF_PH_TWO;
        SDF_PH_TWO: phase_next = SDF_PH_MANY;
        default: phase_next = SDF_PH_MANY;
      endcase
      if (periodsDone >= needOrder) begin
        valid_next = 1'b1;
        ready_next = 1'b1; // Set wins over a same-cycle read
        order_next = needOrder;
        case (needOrder)
          2'h1: data_next = comb1;
          2'h2: data_next = comb2;
          default: data_next = comb3;
        endcase
      end
    end
    if (cfgRestart) begin
      phase_next = SDF_PH_NONE;
      valid_next = 1'b0;
    end
  end

  // Registers of the filter, bus and settling logic
  always_ff @(posedge clk_sys) begin
    bitS1_reg <= modBit; // Pin synchroniser, first stage
    bitS2_reg <= bitS1_reg;
    if (rst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 32'h0000_0000;
      rdData_reg <= 32'h0000_0000;
      ctrl_reg <= `SDF_CTRL_RST;
      decim_reg <= `SDF_DECIM_RST;
      ready_reg <= 1'b0;
      order_reg <= 2'h0;
      data_reg <= '0;
      int1_reg <= '0;
      int2_reg <= '0;
      int3_reg <= '0;
      h2a_reg <= '0;
      h2b_reg <= '0;
      h3a_reg <= '0;
      h3b_reg <= '0;
      h3c_reg <= '0;
      h3d_reg <= '0;
      decCnt_reg <= 11'h000;
      phase_reg <= SDF_PH_NONE;
      valid_reg <= 1'b0;
    end else begin
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      rdData_reg <= rdData_next;
      ctrl_reg <= ctrl_next;
      decim_reg <= decim_next;
      ready_reg <= ready_next;
      order_reg <= order_next;
      data_reg <= data_next;
      int1_reg <= int1_next;
      int2_reg <= int2_next;
      int3_reg <= int3_next;
      h2a_reg <= h2a_next;
      h2b_reg <= h2b_next;
      h3a_reg <= h3a_next;
      h3b_reg <= h3b_next;
      h3c_reg <= h3c_next;
      h3d_reg <= h3d_next;
      decCnt_reg <= decCnt_next;
      phase_reg <= phase_next;
      valid_reg <= valid_next;
    end
  end
endmodule

/* common/sdf_regs.svh */
// Purpose: Offsets, field positions, reset values and rate counts for the sinc filter
// Assumes: 32-bit AHB-Lite register words, one aligned word each
// Notes: Included by bare name; definitions only
// How it works
// - positive differential input gives positive code
// - results span one, two or three periods
// - auto mode steps fast, sinc2 once, sinc3
// - decimation ratio limited to 20..2047
// - modulator rate is oscillator over 128/256
// - one result per output period, from period N of a restart in sincN modes
// - sampling rate scaled by gain-dependent factor
`ifndef SDF_REGS_SVH
`define SDF_REGS_SVH

`define SDF_CTRL_OFS 32'h0000_0000
`define SDF_DECIM_OFS 32'h0000_0004
`define SDF_STATUS_OFS 32'h0000_0008
`define SDF_DATA_LO_OFS 32'h0000_000C
`define SDF_DATA_HI_OFS 32'h0000_0010

`define SDF_CTRL_MODE_LSB 0
`define SDF_CTRL_SPEED_BIT 2
`define SDF_CTRL_GAIN_LSB 3
`define SDF_CTRL_CHAN_LSB 6
`define SDF_CTRL_WIDTH 9

`define SDF_STAT_READY_BIT 0
`define SDF_STAT_ORDER_LSB 1
`define SDF_STAT_SETTLING_BIT 3

`define SDF_CTRL_RST 9'h003
`define SDF_DECIM_RST 11'h014
`define SDF_DECIM_MIN 11'h014
`define SDF_DECIM_MAX 11'h7FF

`define SDF_DIV_FAST 9'h080
`define SDF_DIV_SLOW 9'h100

`endif

/* common/sdf_pkg.sv */
// Purpose: Types shared by the sinc filter design files
// Assumes: Numeric constants live in sdf_regs.svh
// Notes: Phase codes are Gray along the settling path
package sdf_pkg;

  // Filter selection as seen in the control word
  typedef enum logic [1:0] {
    SDF_FILT_FAST = 2'h0,
    SDF_FILT_SINC2 = 2'h1,
    SDF_FILT_SINC3 = 2'h2,
    SDF_FILT_AUTO = 2'h3
  } sdf_filt_t;

  // Output periods completed since the last restart, saturating
  typedef enum logic [1:0] {
    SDF_PH_NONE = 2'h0,
    SDF_PH_ONE = 2'h1,
    SDF_PH_TWO = 2'h3,
    SDF_PH_MANY = 2'h2
  } sdf_phase_t;

  // PGA setting code: gain is two to the power of the code
  typedef logic [2:0] sdf_gain_t;

endpackage

/* logic/sdf_rate_gen.sv */
// Purpose: Modulator and input-sampling strobes derived from the oscillator clock
// Assumes: clk_sys is the oscillator; divisors are powers of two
// Notes: Counter restarts with the filter so periods line up with results
`timescale 1ns/10ps
`include "sdf_regs.svh"
module sdf_rate_gen (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic restart,
  input wire logic speedSel,
  input wire sdf_pkg::sdf_gain_t gainCode,
  output logic modTick,
  output logic sampTick
);
  import sdf_pkg::*;

  logic [8:0] divCnt_reg;
  logic [8:0] divCnt_next;
  logic [8:0] divisor;
  logic [8:0] sampMask;

  // Gain-dependent speed-up of the sampling switch
  function automatic logic [8:0] samp_mask(input logic [8:0] div, input sdf_gain_t g);
    logic [8:0] per;
    per = div;
    if (g >= 3'h5) begin
      per = div >> 4; // Gains 32..128 run sixteen times faster
    end else if (g == 3'h4) begin
      per = div >> 3; // Gain 16 runs eight times faster
    end
    samp_mask = per - 9'h001;
  endfunction

  // Divider select and tick decode
  always_comb begin
    divisor = speedSel ? `SDF_DIV_SLOW : `SDF_DIV_FAST;
    sampMask = samp_mask(divisor, gainCode);
    modTick = (divCnt_reg == divisor - 9'h001);
    sampTick = ((divCnt_reg & sampMask) == sampMask);
    divCnt_next = (modTick || restart) ? 9'h000 : divCnt_reg + 9'h001;
  end

  // Divider state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divCnt_reg <= 9'h000;
    end else begin
      divCnt_reg <= divCnt_next;
    end
  end
endmodule

/* verification/sdf_filter_props.sv */
// Purpose: Port-level checks of the sinc filter top
// Assumes: One clock domain, synchronous active-high reset
// Notes: Writes blank the period check, since they may restart the divider
`timescale 1ns/10ps
`include "sdf_regs.svh"
module sdf_filter_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic modBit,
  input wire logic modStrobe,
  input wire logic sampleStrobe,
  input wire logic [2:0] channelSel,
  input wire logic resultValid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [8:0] modGap_reg, modGap_next;
  logic [11:0] resGap_reg, resGap_next;
  logic clean_reg, clean_next, lastWr_reg, lastWr_next;
  wire logic taken = hsel && hready && htrans[1];
  // Gap counters; the result gap saturates so idle stretches never wrap
  always_comb begin
    modGap_next = modStrobe ? 9'h000 : modGap_reg + 9'h001;
    resGap_next = resultValid ? 12'h000 : resGap_reg + {11'h000, resGap_reg != 12'hFFF};
    lastWr_next = taken && hwrite;
    clean_next = (lastWr_next || lastWr_reg) ? 1'b0 : (modStrobe || clean_reg);
  end
  // Helper registers
  always_ff @(posedge clk_sys) begin
    modGap_reg <= rst ? 9'h000 : modGap_next;
    resGap_reg <= rst ? 12'hFFF : resGap_next;
    lastWr_reg <= rst ? 1'b0 : lastWr_next;
    clean_reg <= rst ? 1'b0 : clean_next;
  end
  sequence ctrlWr;
    taken && hwrite && haddr == `SDF_CTRL_OFS;
  endsequence
  sequence holeRd;
    taken && !hwrite && haddr == 32'h0000_0020;
  endsequence
  AST_MOD_PERIOD: assert property (modStrobe && clean_reg |-> modGap_reg == 9'h07F || modGap_reg == 9'h0FF)
    else $error("modulator strobe spacing wrong");
  AST_SAMP_ALIGN: assert property (modStrobe |-> sampleStrobe)
    else $error("sampling strobe missing at modulator strobe");
  AST_RES_SPACING: assert property (resultValid |-> resGap_reg >= 12'h9FF)
    else $error("results closer than one output period");
  AST_RES_PULSE: assert property (resultValid |=> !resultValid [*8])
    else $error("result pulse too long");
  AST_RES_AFTER_MOD: assert property (resultValid |-> $past(modStrobe))
    else $error("result not after a modulator strobe");
  AST_CHAN_SEL: assert property (ctrlWr ##1 1'b1 |=> channelSel == $past(hwdata[8:6]))
    else $error("channel select not updated");
  AST_BUS_OKAY: assert property (1'b1 |-> hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_HOLE_READ: assert property (holeRd |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_RESET_OUT: assert property ($fell(rst) |-> !resultValid && channelSel == 3'h0)
    else $error("outputs not cleared by reset");
endmodule

bind sdf_filter sdf_filter_props u_props (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .modBit(modBit),
  .modStrobe(modStrobe), .sampleStrobe(sampleStrobe), .channelSel(channelSel),
  .resultValid(resultValid));

/* verification/sdf_mod_model.sv */
// Purpose: Behavioural modulator front end driving the bitstream pin
// Assumes: posIn high stands for a positive differential input
// Notes: The bit moves only after a modulator strobe, as the real loop would
`timescale 1ns/10ps
module sdf_mod_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic modStrobe,
  input wire logic posIn,
  output logic modBit
);
  logic bitNext;
  // Full-scale input: every modulator decision follows the input sign
  always_comb bitNext = modStrobe ? posIn : modBit;
  always_ff @(posedge clk_sys) modBit <= rst ? 1'b1 : bitNext;
endmodule

/* verification/testbench.sv */
// Purpose: Self-checking bench for the sinc filter
// Assumes: hready is tied to hreadyout; one slave on the bus
// Notes: Constant bitstreams give exact sums N, N^2, N^3
`timescale 1ns/10ps
`include "sdf_regs.svh"
module testbench;
  import sdf_pkg::*;
  logic clk_sys = 1'b0;
  logic rst, hsel, hwrite, posIn;
  logic [31:0] haddr, hwdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [63:0] r;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, modBit, modStrobe, sampleStrobe, resultValid;
  wire logic [2:0] channelSel;
  int bad_count = 0;
  int cmp_count = 0;
  always #2 clk_sys = ~clk_sys;
  sdf_filter u_dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .modBit(modBit), .modStrobe(modStrobe),
    .sampleStrobe(sampleStrobe), .channelSel(channelSel), .resultValid(resultValid));
  sdf_mod_model u_mod (.clk_sys(clk_sys), .rst(rst), .modStrobe(modStrobe), .posIn(posIn),
    .modBit(modBit));
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask
  // One single AHB-Lite transfer; read data lands in q
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    q = hrdata;
  endtask
  // Cycles between two strobes, bounded so a dead strobe cannot hang
  task period(input bit samp, output int n);
    n = 0;
    @(posedge clk_sys);
    while ((samp ? sampleStrobe : modStrobe) !== 1'b1 && n < 600) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((samp ? sampleStrobe : modStrobe) !== 1'b1 && n < 600);
  endtask
  function automatic logic [63:0] exp_sum(input int ord, input bit neg);
    logic [63:0] v;
    v = 64'h1;
    for (int i = 0; i < ord; i++) v = v * 64'h14;
    return neg ? -v : v;
  endfunction
  // Wait for a result, then read it high word first; p counts periods since restart
  task get_res(input int ord, input int p, input bit neg);
    int n;
    n = 0;
    while (resultValid !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(64'(n < 20000), 64'h1);
    bus(1'b0, `SDF_STATUS_OFS, 32'h0);
    chk(64'(q[`SDF_STAT_READY_BIT]), 64'h1);
    chk(64'(q[`SDF_STAT_ORDER_LSB +: 2]), 64'(ord));
    chk(64'(q[`SDF_STAT_SETTLING_BIT]), 64'(p < 3));
    bus(1'b0, `SDF_DATA_HI_OFS, 32'h0);
    r[63:32] = q;
    bus(1'b0, `SDF_DATA_LO_OFS, 32'h0);
    r[31:0] = q;
    chk(r, exp_sum(ord, neg));
    bus(1'b0, `SDF_STATUS_OFS, 32'h0);
    chk(64'(q[`SDF_STAT_READY_BIT]), 64'h0);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end
  initial begin
    int n;
    int g;
    logic [2:0] ch;
    bit neg;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    posIn = 1'b1;
    void'($urandom(40));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, `SDF_CTRL_OFS, 32'h0);
    chk(64'(q[8:0]), 64'(`SDF_CTRL_RST));
    bus(1'b0, `SDF_DECIM_OFS, 32'h0);
    chk(64'(q[10:0]), 64'(`SDF_DECIM_RST));
    bus(1'b0, 32'h0000_0020, 32'h0);
    chk(64'(q), 64'h0);
    bus(1'b1, `SDF_DECIM_OFS, 32'h5);
    bus(1'b0, `SDF_DECIM_OFS, 32'h0);
    chk(64'(q[10:0]), 64'h14);
    bus(1'b1, `SDF_DECIM_OFS, 32'h7FF);
    bus(1'b0, `SDF_DECIM_OFS, 32'h0);
    chk(64'(q[10:0]), 64'h7FF);
    bus(1'b1, `SDF_DECIM_OFS, 32'h14);
    $display("test registers done");
    // Divider and sampling rates over speed and gain corners
    for (int k = 0; k < 4; k++) begin
      g = (k < 2) ? 0 : 2 * k; // Codes 4 and 6 reach the x8 and x16 factors
      bus(1'b1, `SDF_CTRL_OFS, 32'((g << `SDF_CTRL_GAIN_LSB) | (k % 2) << `SDF_CTRL_SPEED_BIT));
      period(1'b0, n);
      chk(64'(n), 64'(128 << (k % 2)));
      period(1'b1, n);
      chk(64'(n), 64'((128 << (k % 2)) / (g < 4 ? 1 : (g == 4 ? 8 : 16))));
    end
    $display("test rates done");
    // Every filter mode with a random sign and channel
    for (int m = 0; m < 4; m++) begin
      neg = 1'($urandom % 2);
      ch = 3'($urandom % 8);
      posIn <= ~neg;
      repeat (300) @(posedge clk_sys);
      bus(1'b1, `SDF_CTRL_OFS, 32'h4);
      bus(1'b1, `SDF_CTRL_OFS, 32'((ch << `SDF_CTRL_CHAN_LSB) | m));
      @(posedge clk_sys); // Control word settles at the write's data-phase edge
      chk(64'(channelSel), 64'(ch));
      for (int k = 0; k < 3; k++) begin
        n = (m == 3) ? 1 : m + 1; // First period that yields a result
        get_res((m == 3) ? k + 1 : m + 1, n + k, neg);
      end
      $display("test mode %0d done", m);
    end
    end_sim();
  end
endmodule
